// File: verilog/cci_defs.svh
/*
 Constants of the compass command interpreter: command codes, nonvolatile
 map offsets, factory defaults, mode bit positions and output limits.
 Assumes inclusion by the top module only, by bare name.
*/
// Summary of operation
// R1 - master writes commands to the bus address with bit 0 clear, factory 0x32.
// R2 - after the write address, one to three bytes form command and arguments.
// R3 - order is command byte, argument high byte, argument low byte.
// R4 - read bytes depend only on the last command, no register pointer.
// R5 - every received byte of a write frame is acknowledged.
// R6 - master reads with address bit 0 set, factory 0x33, then clocks bytes.
// R7 - angles in tenths of a degree: heading 0 to 3600, tilt within 900.
// R8 - 0x40 returns accel X, Y, Z, high byte first.
// R9 - 0x45 returns field X, Y, Z, high byte first.
// R10 - 0x50 returns heading, fore tilt, side tilt, high byte first.
// R11 - 0x55 returns fore tilt, side tilt, temperature, high byte first.
// R12 - 0x65 returns one byte: the live operating configuration A.
// R13 - 0x71 enters hard-iron calibration, 0x7E leaves it, no reply.
// R14 - 0x72, 0x73, 0x74 pick level, upright edge, upright front orientation.
// R15 - 0x75 moves standby to run mode.
// R16 - 0x76 moves run mode to standby.
// R17 - 0x83 moves run to sleep, 0x84 moves sleep to standby.
// R18 - factory map: address 0x32, config A 0x11, config B 0x01.
// R19 - mount correction and declination are 16-bit, limited to 1800 either way.
// R20 - hard-iron offsets live at 0x0E to 0x13, default zero.
// R21 - smoothing weight at 0x14, its high byte at 0x15 stays zero.
// R22 - serial number at 0x06/0x07 low first, date code at 0x08/0x09.
// R23 - 0xE1 reads one location, 0xF1 writes location then data.
// R24 - 0x82 restarts, reloading working settings from the map.
// R25 - a new bus address applies only after reset or restart command.
// R26 - correction angles are two's complement signed.
// R27 - hard-iron offsets are copied to working registers at power-up.
// R28 - heading smoothing is active only in run mode.
`ifndef CCI_DEFS_SVH
`define CCI_DEFS_SVH
`define CCI_CMD_ACCEL 8'h40
`define CCI_CMD_FIELD 8'h45
`define CCI_CMD_HEAD 8'h50
`define CCI_CMD_TILT 8'h55
`define CCI_CMD_OPM 8'h65
`define CCI_CMD_CAL_ON 8'h71
`define CCI_CMD_LEVEL 8'h72
`define CCI_CMD_EDGE 8'h73
`define CCI_CMD_FRONT 8'h74
`define CCI_CMD_RUN 8'h75
`define CCI_CMD_STBY 8'h76
`define CCI_CMD_CAL_OFF 8'h7E
`define CCI_CMD_RESTART 8'h82
`define CCI_CMD_SLEEP 8'h83
`define CCI_CMD_WAKE 8'h84
`define CCI_CMD_EE_RD 8'hE1
`define CCI_CMD_EE_WR 8'hF1
`define CCI_EE_DEPTH 22
`define CCI_EE_ADDR 5'h00
`define CCI_EE_FWREV 5'h02
`define CCI_EE_CFG_A 5'h04
`define CCI_EE_CFG_B 5'h05
`define CCI_EE_SER_LO 5'h06
`define CCI_EE_SER_HI 5'h07
`define CCI_EE_YEAR 5'h08
`define CCI_EE_WEEK 5'h09
`define CCI_EE_MOUNT_LO 5'h0A
`define CCI_EE_MOUNT_HI 5'h0B
`define CCI_EE_DECL_LO 5'h0C
`define CCI_EE_DECL_HI 5'h0D
`define CCI_EE_BIAS_X_LO 5'h0E
`define CCI_EE_BIAS_X_HI 5'h0F
`define CCI_EE_BIAS_Y_LO 5'h10
`define CCI_EE_BIAS_Y_HI 5'h11
`define CCI_EE_BIAS_Z_LO 5'h12
`define CCI_EE_BIAS_Z_HI 5'h13
`define CCI_EE_SMOOTH_LO 5'h14
`define CCI_EE_SMOOTH_HI 5'h15
`define CCI_DEF_ADDR 8'h32
`define CCI_DEF_CFG_A 8'h11
`define CCI_DEF_CFG_B 8'h01
`define CCI_OPA_COMP 7
`define CCI_OPA_CAL 6
`define CCI_OPA_FILT 5
`define CCI_OPA_RUN 4
`define CCI_OPA_STBY 3
`define CCI_ORI_LEVEL 3'h1
`define CCI_ORI_EDGE 3'h2
`define CCI_ORI_FRONT 3'h4
`define CCI_HEAD_MAX 16'h0E10
`define CCI_TILT_MAX 16'h0384
`define CCI_ANGLE_MAX 16'h0708
`define CCI_RESP_MAX 4'h6
`define CCI_FILL 8'h00
`endif

// File: verilog/cci_pkg.sv
/*
 Types of the compass command interpreter: link and power states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package cci_pkg;
  typedef enum logic [2:0] {
    CCI_LNK_IDLE = 3'h0,
    CCI_LNK_ADDR = 3'h1,
    CCI_LNK_AACK = 3'h3,
    CCI_LNK_WR = 3'h2,
    CCI_LNK_WACK = 3'h6,
    CCI_LNK_RD = 3'h7,
    CCI_LNK_RACK = 3'h5
  } cci_link_t;
  typedef enum logic [1:0] {
    CCI_PWR_STBY = 2'h0,
    CCI_PWR_RUN = 2'h1,
    CCI_PWR_SLEEP = 2'h3
  } cci_pwr_t;
endpackage : cci_pkg

// File: verilog/cci_compass_cmd.sv
/*
 Command interpreter of the compass: two-wire slave on the link clock,
 command decode, response bytes, nonvolatile map and working settings.
 Assumes sensor and angle inputs come from logic on clk_sys, and that
 the bus master leaves far more than a few clk_sys cycles between frames.
*/
`timescale 1ns/10ps
`include "cci_defs.svh"
module cci_compass_cmd #(
  parameter logic [7:0] FW_REV = 8'h10,
  parameter logic [15:0] SERIAL_NUM = 16'h0001,
  parameter logic [7:0] BUILD_YEAR = 8'h00,
  parameter logic [7:0] BUILD_WEEK = 8'h00,
  parameter int EE_DEPTH = `CCI_EE_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [15:0] accel_x,
  input wire logic [15:0] accel_y,
  input wire logic [15:0] accel_z,
  input wire logic [15:0] field_x,
  input wire logic [15:0] field_y,
  input wire logic [15:0] field_z,
  input wire logic [15:0] heading,
  input wire logic [15:0] tilt_fore,
  input wire logic [15:0] tilt_side,
  input wire logic [15:0] thermal,
  output cci_pkg::cci_pwr_t pwr_mode,
  output logic calib_active,
  output logic [2:0] orient,
  output logic filter_active,
  output logic [7:0] smoothing_weight,
  output logic [1:0] rate_sel,
  output logic [15:0] iron_bias_x,
  output logic [15:0] iron_bias_y,
  output logic [15:0] iron_bias_z,
  output logic [15:0] mount_correction,
  output logic [15:0] declination,
  output logic [6:0] bus_address
);
  import cci_pkg::*;

  localparam logic [7:0] DEF_ADDR = `CCI_DEF_ADDR;
  localparam logic [7:0] DEF_CFG_A = `CCI_DEF_CFG_A;
  localparam logic [7:0] DEF_CFG_B = `CCI_DEF_CFG_B;

  // ==========================================================
  // functions
  function automatic logic [15:0] clamp_u(input logic [15:0] v, input logic [15:0] lim);
    clamp_u = (v > lim) ? lim : v;
  endfunction : clamp_u

  function automatic logic [15:0] clamp_s(input logic [15:0] v, input logic [15:0] lim);
    logic signed [15:0] sv;
    logic signed [15:0] sl;
    sv = v;
    sl = lim;
    if (sv > sl) begin
      clamp_s = lim;
    end else if (sv < -sl) begin
      clamp_s = 16'(-sl);
    end else begin
      clamp_s = v;
    end
  endfunction : clamp_s

  function automatic logic [7:0] ee_default(input logic [4:0] a);
    case (a)
      `CCI_EE_ADDR: ee_default = DEF_ADDR;
      `CCI_EE_FWREV: ee_default = FW_REV;
      `CCI_EE_CFG_A: ee_default = DEF_CFG_A;
      `CCI_EE_CFG_B: ee_default = DEF_CFG_B;
      `CCI_EE_SER_LO: ee_default = SERIAL_NUM[7:0];
      `CCI_EE_SER_HI: ee_default = SERIAL_NUM[15:8];
      `CCI_EE_YEAR: ee_default = BUILD_YEAR;
      `CCI_EE_WEEK: ee_default = BUILD_WEEK;
      default: ee_default = 8'h00;
    endcase
  endfunction : ee_default

  function automatic logic ee_writable(input logic [7:0] a);
    ee_writable = (a < 8'(EE_DEPTH)) && (a != 8'h01) && (a != 8'h03) &&
                  ((a < 8'(`CCI_EE_FWREV)) || (a > 8'(`CCI_EE_WEEK)) ||
                   (a == 8'(`CCI_EE_CFG_A)) || (a == 8'(`CCI_EE_CFG_B)));
  endfunction : ee_writable

  // ==========================================================
  // link domain: frame start, bit engine, acknowledge
  logic start_tog_q;
  logic start_seen_q;
  cci_link_t lnk_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic rw_q;
  logic [1:0] widx_q;
  logic [2:0] ridx_q;
  logic wr_tog_q;
  logic [7:0] wbyte_q;
  logic [1:0] wbidx_q;
  logic [7:0] resp_q [0:7];
  logic [3:0] resp_len_q;
  logic [6:0] addr_q;

  wire start_new = start_tog_q != start_seen_q;
  wire bit_last = bit_q == 3'h7;
  wire addr_hit = sh_q[6:0] == addr_q;
  wire [2:0] rbit = 3'h7 - bit_q;
  wire [7:0] rd_byte = ({1'b0, ridx_q} < resp_len_q) ? resp_q[ridx_q] : `CCI_FILL;

  // start: data falls while the link clock is high
  always_ff @(negedge sda_in or negedge rst_b) begin
    if (!rst_b) begin
      start_tog_q <= 1'b0;
    end else if (scl_clk) begin
      start_tog_q <= ~start_tog_q;
    end
  end

  always_ff @(posedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_seen_q <= 1'b0;
      lnk_q <= CCI_LNK_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      widx_q <= 2'h0;
      ridx_q <= 3'h0;
      wr_tog_q <= 1'b0;
      wbyte_q <= 8'h00;
      wbidx_q <= 2'h0;
    end else begin
      start_seen_q <= start_tog_q;
      bit_q <= bit_q + 3'h1;
      sh_q <= {sh_q[6:0], sda_in};
      if (start_new) begin
        lnk_q <= CCI_LNK_ADDR;
        bit_q <= 3'h1;
      end else begin
        case (lnk_q)
          CCI_LNK_ADDR: begin
            if (bit_last) begin
              rw_q <= sda_in;
              lnk_q <= addr_hit ? CCI_LNK_AACK : CCI_LNK_IDLE; // R1 R6
            end
          end
          CCI_LNK_AACK: begin
            bit_q <= 3'h0;
            widx_q <= 2'h0;
            ridx_q <= 3'h0;
            lnk_q <= rw_q ? CCI_LNK_RD : CCI_LNK_WR;
          end
          CCI_LNK_WR: begin
            if (bit_last) begin
              wr_tog_q <= ~wr_tog_q;
              wbyte_q <= {sh_q[6:0], sda_in};
              wbidx_q <= widx_q; // R2 R3
              lnk_q <= CCI_LNK_WACK;
              if (widx_q != 2'h3) begin
                widx_q <= widx_q + 2'h1;
              end
            end
          end
          CCI_LNK_WACK: begin
            bit_q <= 3'h0;
            lnk_q <= CCI_LNK_WR;
          end
          CCI_LNK_RD: begin
            if (bit_last) begin
              lnk_q <= CCI_LNK_RACK;
            end
          end
          CCI_LNK_RACK: begin
            bit_q <= 3'h0;
            if (ridx_q != 3'h7) begin
              ridx_q <= ridx_q + 3'h1;
            end
            lnk_q <= sda_in ? CCI_LNK_IDLE : CCI_LNK_RD;
          end
          default: lnk_q <= CCI_LNK_IDLE;
        endcase
      end
    end
  end

  // drive on the falling edge so data is stable through the high phase
  always_ff @(negedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      sda_out <= 1'b0;
      if (lnk_q == CCI_LNK_AACK || lnk_q == CCI_LNK_WACK) begin
        sda_oe_n <= 1'b0; // R5
      end else if (lnk_q == CCI_LNK_RD) begin
        sda_oe_n <= rd_byte[rbit]; // R4 R6
      end else begin
        sda_oe_n <= 1'b1;
      end
    end
  end

  // ==========================================================
  // system domain: byte crossing and command decode
  logic [2:0] wsync_q;
  logic [7:0] cmd_q;
  logic [7:0] arg1_q;
  logic [7:0] ee_q [0:EE_DEPTH-1];
  logic reload_q;
  cci_pwr_t pwr_q;
  logic cal_q;
  logic filt_q;
  logic [2:0] orient_q;

  // byte and index are held by the link until the next byte, far later
  wire wr_evt = wsync_q[2] ^ wsync_q[1];
  wire evt_cmd = wr_evt && (wbidx_q == 2'h0);
  wire evt_arg1 = wr_evt && (wbidx_q == 2'h1);
  wire evt_arg2 = wr_evt && (wbidx_q == 2'h2);
  wire [7:0] wb = wbyte_q;
  wire is_sensor = (wb == `CCI_CMD_ACCEL) || (wb == `CCI_CMD_FIELD) ||
                   (wb == `CCI_CMD_HEAD) || (wb == `CCI_CMD_TILT);
  wire [7:0] opm_a = {pwr_q == CCI_PWR_RUN, cal_q, filt_q, pwr_q == CCI_PWR_RUN,
                      pwr_q == CCI_PWR_STBY, orient_q};
  wire [15:0] head_c = clamp_u(heading, `CCI_HEAD_MAX); // R7
  wire [15:0] fore_c = clamp_s(tilt_fore, `CCI_TILT_MAX); // R7
  wire [15:0] side_c = clamp_s(tilt_side, `CCI_TILT_MAX); // R7
  wire [47:0] snap_accel = {accel_x, accel_y, accel_z}; // R8
  wire [47:0] snap_field = {field_x, field_y, field_z}; // R9
  wire [47:0] snap_head = {head_c, fore_c, side_c}; // R10
  wire [47:0] snap_tilt = {fore_c, side_c, thermal}; // R11
  wire [47:0] resp_new = (wb == `CCI_CMD_ACCEL) ? snap_accel :
                         (wb == `CCI_CMD_FIELD) ? snap_field :
                         (wb == `CCI_CMD_HEAD) ? snap_head :
                         (wb == `CCI_CMD_TILT) ? snap_tilt :
                         {opm_a, 40'h0}; // R12
  wire [3:0] resp_len_new = is_sensor ? `CCI_RESP_MAX : (wb == `CCI_CMD_OPM) ? 4'h1 : 4'h0;
  wire [7:0] ee_rd_byte = (wb < 8'(EE_DEPTH)) ? ee_q[wb[4:0]] : `CCI_FILL;
  wire ee_we = evt_arg2 && (cmd_q == `CCI_CMD_EE_WR) && ee_writable(arg1_q); // R23
  wire [7:0] ee_wdata = (arg1_q[4:0] == `CCI_EE_SMOOTH_HI) ? 8'h00 : wb; // R21
  wire [7:0] cfg_a = ee_q[`CCI_EE_CFG_A];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wsync_q <= 3'h0;
    end else begin
      wsync_q <= {wsync_q[1:0], wr_tog_q};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cmd_q <= 8'h00;
      arg1_q <= 8'h00;
    end else if (evt_cmd) begin
      cmd_q <= wb;
    end else if (evt_arg1) begin
      arg1_q <= wb;
    end
  end

  // map: reset stands for power-up of a part fresh from the factory
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < EE_DEPTH; i++) begin
        ee_q[i] <= ee_default(5'(i)); // R18 R20 R22
      end
    end else if (ee_we) begin
      ee_q[arg1_q[4:0]] <= ee_wdata;
    end
  end

  // response bytes follow the last command only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 8; i++) begin
        resp_q[i] <= 8'h00;
      end
      resp_len_q <= 4'h0;
    end else if (evt_cmd) begin
      for (int i = 0; i < 6; i++) begin
        resp_q[i] <= resp_new[47-8*i -: 8]; // R4
      end
      resp_len_q <= resp_len_new;
    end else if (evt_arg1 && cmd_q == `CCI_CMD_EE_RD) begin
      resp_q[0] <= ee_rd_byte; // R23
      resp_len_q <= 4'h1;
    end
  end

  // ==========================================================
  // modes and working settings
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reload_q <= 1'b1;
      pwr_q <= CCI_PWR_RUN;
      cal_q <= 1'b0;
      filt_q <= 1'b0;
      orient_q <= `CCI_ORI_LEVEL;
    end else if (reload_q) begin
      reload_q <= 1'b0;
      pwr_q <= cfg_a[`CCI_OPA_RUN] ? CCI_PWR_RUN : CCI_PWR_STBY; // R24
      cal_q <= 1'b0;
      filt_q <= cfg_a[`CCI_OPA_FILT];
      orient_q <= cfg_a[2:0];
    end else if (evt_cmd) begin
      case (wb)
        `CCI_CMD_CAL_ON: cal_q <= 1'b1; // R13
        `CCI_CMD_CAL_OFF: cal_q <= 1'b0; // R13
        `CCI_CMD_LEVEL: orient_q <= `CCI_ORI_LEVEL; // R14
        `CCI_CMD_EDGE: orient_q <= `CCI_ORI_EDGE; // R14
        `CCI_CMD_FRONT: orient_q <= `CCI_ORI_FRONT; // R14
        `CCI_CMD_RUN: begin
          if (pwr_q == CCI_PWR_STBY) pwr_q <= CCI_PWR_RUN; // R15
        end
        `CCI_CMD_STBY: begin
          if (pwr_q == CCI_PWR_RUN) pwr_q <= CCI_PWR_STBY; // R16
        end
        `CCI_CMD_SLEEP: begin
          if (pwr_q == CCI_PWR_RUN) pwr_q <= CCI_PWR_SLEEP; // R17
        end
        `CCI_CMD_WAKE: begin
          if (pwr_q == CCI_PWR_SLEEP) pwr_q <= CCI_PWR_STBY; // R17
        end
        `CCI_CMD_RESTART: reload_q <= 1'b1; // R24
        default: reload_q <= 1'b0;
      endcase
    end
  end

  // working copies change only at reload, so map writes wait for restart
  logic filt_run_q;
  logic [7:0] smooth_q;
  logic [1:0] rate_q;
  logic [15:0] bias_x_q;
  logic [15:0] bias_y_q;
  logic [15:0] bias_z_q;
  logic [15:0] mount_q;
  logic [15:0] decl_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= DEF_ADDR[7:1];
      smooth_q <= 8'h00;
      rate_q <= DEF_CFG_B[1:0];
      bias_x_q <= 16'h0000;
      bias_y_q <= 16'h0000;
      bias_z_q <= 16'h0000;
      mount_q <= 16'h0000;
      decl_q <= 16'h0000;
    end else if (reload_q) begin
      addr_q <= ee_q[`CCI_EE_ADDR][7:1]; // R25
      smooth_q <= ee_q[`CCI_EE_SMOOTH_LO]; // R21
      rate_q <= ee_q[`CCI_EE_CFG_B][1:0];
      bias_x_q <= {ee_q[`CCI_EE_BIAS_X_HI], ee_q[`CCI_EE_BIAS_X_LO]}; // R27
      bias_y_q <= {ee_q[`CCI_EE_BIAS_Y_HI], ee_q[`CCI_EE_BIAS_Y_LO]}; // R27
      bias_z_q <= {ee_q[`CCI_EE_BIAS_Z_HI], ee_q[`CCI_EE_BIAS_Z_LO]}; // R27
      mount_q <= clamp_s({ee_q[`CCI_EE_MOUNT_HI], ee_q[`CCI_EE_MOUNT_LO]}, `CCI_ANGLE_MAX); // R19 R26
      decl_q <= clamp_s({ee_q[`CCI_EE_DECL_HI], ee_q[`CCI_EE_DECL_LO]}, `CCI_ANGLE_MAX); // R19 R26
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      filt_run_q <= 1'b0;
    end else begin
      filt_run_q <= filt_q && (pwr_q == CCI_PWR_RUN); // R28
    end
  end

  assign pwr_mode = pwr_q;
  assign calib_active = cal_q;
  assign orient = orient_q;
  assign filter_active = filt_run_q;
  assign smoothing_weight = smooth_q;
  assign rate_sel = rate_q;
  assign iron_bias_x = bias_x_q;
  assign iron_bias_y = bias_y_q;
  assign iron_bias_z = bias_z_q;
  assign mount_correction = mount_q;
  assign declination = decl_q;
  assign bus_address = addr_q;
endmodule : cci_compass_cmd

// File: verification/cci_master_model.sv
/*
 Two-wire bus master model: command write frames and response read frames.
 Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/10ps
module cci_master_model (
  output logic scl_clk,
  output logic sda_drv,
  input wire logic sda_line
);
  // ==========
  // bit level
  initial begin
    scl_clk = 1'b1;
    sda_drv = 1'b1;
  end
  // data moves only while the clock is low; the clock stands high between frames
  task automatic bit_io(input logic b, output logic s);
    #20 sda_drv = b;
    #20 scl_clk = 1'b1;
    s = sda_line;
    #40 scl_clk = 1'b0;
  endtask : bit_io
  task automatic put(input logic [7:0] v, inout int nak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], s);
    end
    bit_io(1'b1, s);
    if (s !== 1'b0) begin
      nak++;
    end
  endtask : put
  task automatic get(input logic last, inout logic [63:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d = {d[62:0], s};
    end
    bit_io(last, s);
  endtask : get
  // ==========
  // frames
  task automatic edge_start;
    #13 sda_drv = 1'b0;
    #40 scl_clk = 1'b0;
  endtask : edge_start
  task automatic edge_stop;
    #20 sda_drv = 1'b0;
    #20 scl_clk = 1'b1;
    #20 sda_drv = 1'b1;
  endtask : edge_stop
  task automatic wr(input logic [7:0] adr, input logic [23:0] b, input int n, output int nak);
    nak = 0;
    edge_start();
    put({adr[7:1], 1'b0}, nak);
    for (int k = 0; k < n; k++) begin
      put(b[23 - 8 * k -: 8], nak);
    end
    edge_stop();
  endtask : wr
  task automatic rd(input logic [7:0] adr, input int n, output logic [63:0] d, output int nak);
    nak = 0;
    d = 64'h0;
    edge_start();
    put({adr[7:1], 1'b1}, nak);
    for (int k = 1; k <= n; k++) begin
      get(k == n, d);
    end
    edge_stop();
  endtask : rd
endmodule : cci_master_model

// File: verification/cci_compass_cmd_assertions.sv
/*
 Checker of the compass command interpreter, bound to its top module.
 Assumes the link clock is far slower than clk_sys.
*/
`timescale 1ns/10ps
module cci_compass_cmd_assertions (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic scl_clk,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire cci_pkg::cci_pwr_t pwr_mode,
  input wire logic calib_active,
  input wire logic [2:0] orient,
  input wire logic filter_active,
  input wire logic [15:0] mount_correction,
  input wire logic [15:0] declination
);
  import cci_pkg::*;
  logic scl_seen_q;
  logic scl_rose;
  logic [3:0] rise_age_q;
  logic [3:0] rise_age_d;
  // ==========
  // cycles since the last link clock rise
  assign scl_rose = scl_clk && !scl_seen_q;
  assign rise_age_d = scl_rose ? 4'h0 : ((rise_age_q == 4'hF) ? 4'hF : rise_age_q + 4'h1);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      scl_seen_q <= 1'b1;
      rise_age_q <= 4'hF;
    end else begin
      scl_seen_q <= scl_clk;
      rise_age_q <= rise_age_d;
    end
  end
  // ==========
  // properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_ACK_DRIVES_LOW: assert property (!sda_oe_n |-> sda_out == 1'b0)
    else $error("data wire driven high");
  AST_OE_ON_FALL: assert property (scl_clk && $past(scl_clk) |-> $stable(sda_oe_n))
    else $error("data drive changed while link clock high");
  AST_ACK_HELD: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*3])
    else $error("acknowledge shorter than a link clock period");
  AST_FILT_NEEDS_RUN: assert property (filter_active |-> $past(pwr_mode) == CCI_PWR_RUN)
    else $error("filter active outside run mode");
  AST_SLEEP_FROM_RUN: assert property ($changed(pwr_mode) && pwr_mode == CCI_PWR_SLEEP |-> $past(pwr_mode) == CCI_PWR_RUN)
    else $error("sleep entered from a mode other than run");
  AST_MODE_LEGAL: assert property (pwr_mode inside {CCI_PWR_STBY, CCI_PWR_RUN, CCI_PWR_SLEEP})
    else $error("power mode encoding illegal");
  AST_ORIENT_ONEHOT: assert property ($onehot(orient))
    else $error("orientation not one-hot");
  AST_MODE_AFTER_CMD: assert property ($changed(pwr_mode) || $changed(orient) || $changed(calib_active) |-> rise_age_q < 4'h8)
    else $error("mode changed with no command on the link");
  AST_MOUNT_RANGE: assert property (mount_correction[15] ? mount_correction >= 16'hF8F8 : mount_correction <= 16'h0708)
    else $error("mount correction outside limit");
  AST_DECL_RANGE: assert property (declination[15] ? declination >= 16'hF8F8 : declination <= 16'h0708)
    else $error("declination outside limit");
endmodule : cci_compass_cmd_assertions
bind cci_compass_cmd cci_compass_cmd_assertions i_chk (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .scl_clk(scl_clk),
  .sda_out(sda_out),
  .sda_oe_n(sda_oe_n),
  .pwr_mode(pwr_mode),
  .calib_active(calib_active),
  .orient(orient),
  .filter_active(filter_active),
  .mount_correction(mount_correction),
  .declination(declination)
);

// File: verification/test_compass_i2c_command_interpreter.sv
/*
 Self-checking bench of the compass command interpreter.
 Assumes the master model and the checker are compiled before it.
*/
`timescale 1ns/10ps
module test_compass_i2c_command_interpreter;
  import cci_pkg::*;
  logic clk_sys, rst_b, scl_clk, sda_drv, sda_in, sda_out, sda_oe_n, calib_active, filter_active;
  logic [15:0] sens [10];
  cci_pwr_t pwr_mode;
  logic [2:0] orient;
  logic [7:0] smoothing_weight, adr_w;
  logic [1:0] rate_sel;
  logic [15:0] bias_x, bias_y, bias_z, mount_correction, declination;
  logic [6:0] bus_address;
  int n_fail, checked;
  // open drain with pull-up
  assign sda_in = sda_drv & (sda_oe_n | sda_out);
  cci_master_model i_mst (.scl_clk(scl_clk), .sda_drv(sda_drv), .sda_line(sda_in));
  cci_compass_cmd i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .scl_clk(scl_clk), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .accel_x(sens[0]), .accel_y(sens[1]), .accel_z(sens[2]),
    .field_x(sens[3]), .field_y(sens[4]), .field_z(sens[5]), .heading(sens[6]), .tilt_fore(sens[7]),
    .tilt_side(sens[8]), .thermal(sens[9]), .pwr_mode(pwr_mode), .calib_active(calib_active), .orient(orient),
    .filter_active(filter_active), .smoothing_weight(smoothing_weight), .rate_sel(rate_sel),
    .iron_bias_x(bias_x), .iron_bias_y(bias_y), .iron_bias_z(bias_z), .mount_correction(mount_correction),
    .declination(declination), .bus_address(bus_address));
  // ==========
  // helpers
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results;
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  task automatic do_reset;
    @(negedge clk_sys);
    rst_b = 1'b0;
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
    adr_w = 8'h32;
    repeat (4) @(negedge clk_sys);
  endtask : do_reset
  task automatic cmd(input logic [23:0] b, input int n);
    int nak;
    @(negedge clk_sys);
    i_mst.wr(adr_w, b, n, nak);
    check("write ack", 64'(nak), 64'h0);
    repeat (8) @(negedge clk_sys);
  endtask : cmd
  task automatic rsp(input string what, input int n, input logic [63:0] exp);
    logic [63:0] d;
    int nak;
    i_mst.rd(adr_w, n, d, nak);
    check("read ack", 64'(nak), 64'h0);
    check(what, d, exp);
    repeat (4) @(negedge clk_sys);
  endtask : rsp
  // ==========
  // scenarios
  task automatic reset_state;
    check("reset modes", {pwr_mode, orient, calib_active, filter_active, rate_sel, bus_address, smoothing_weight},
      {CCI_PWR_RUN, 3'h1, 1'h0, 1'h0, 2'h1, 7'h19, 8'h00});
    check("reset words", {bias_x, bias_y, bias_z, mount_correction | declination}, 64'h0);
    cmd(24'h650000, 1);
    rsp("reset config byte", 1, 64'h91);
  endtask : reset_state
  task automatic data_reads;
    logic [7:0] code [4] = '{8'h40, 8'h45, 8'h50, 8'h55};
    logic [47:0] exp [4];
    @(negedge clk_sys);
    // heading and side tilt out of range, so the limits must show in the bytes
    sens = '{16'h8001, 16'h7F02, 16'h0103, 16'hA5C3, 16'h5A3C, 16'h00FF, 16'h1000, 16'h0384, 16'hF000, 16'h1234};
    exp = '{{sens[0], sens[1], sens[2]}, {sens[3], sens[4], sens[5]}, {16'h0E10, sens[7], 16'hFC7C},
      {sens[7], 16'hFC7C, sens[9]}};
    for (int k = 0; k < 4; k++) begin
      cmd({code[k], 16'h0000}, 1);
      rsp("sensor bytes", 7, {8'h00, exp[k], 8'h00});
      rsp("sensor repeat", 6, {16'h0000, exp[k]});
    end
  endtask : data_reads
  task automatic mode_cmds;
    logic [13:0] step [11] = '{{8'h76, 2'h0, 3'h1, 1'h0}, {8'h83, 2'h0, 3'h1, 1'h0}, {8'h75, 2'h1, 3'h1, 1'h0},
      {8'h83, 2'h3, 3'h1, 1'h0}, {8'h84, 2'h0, 3'h1, 1'h0}, {8'h75, 2'h1, 3'h1, 1'h0}, {8'h73, 2'h1, 3'h2, 1'h0},
      {8'h74, 2'h1, 3'h4, 1'h0}, {8'h71, 2'h1, 3'h4, 1'h1}, {8'h7E, 2'h1, 3'h4, 1'h0}, {8'h72, 2'h1, 3'h1, 1'h0}};
    for (int k = 0; k < 11; k++) begin
      cmd({step[k][13:6], 16'h0000}, 1);
      check("mode", {pwr_mode, orient, calib_active}, step[k][5:0]);
      if (k == 8) begin
        cmd(24'h650000, 1);
        rsp("config byte", 1, 64'hD4);
      end
    end
  endtask : mode_cmds
  task automatic map_access;
    logic [15:0] rd_tbl [9] = '{16'h0032, 16'h0411, 16'h0501, 16'h0A00, 16'h0210, 16'h0601, 16'h0E00,
      16'h1500, 16'h1600};
    logic [15:0] wr_tbl [9] = '{16'h0A30, 16'h0BF8, 16'h0E5A, 16'h1507, 16'h0255, 16'h0040, 16'h0431, 16'h1404,
      16'h0502};
    logic [15:0] back [4] = '{16'h0A30, 16'h1500, 16'h0210, 16'h0040};
    int nak;
    for (int k = 0; k < 9; k++) begin
      cmd({8'hE1, rd_tbl[k][15:8], 8'h00}, 2);
      rsp("map default", 1, {56'h0, rd_tbl[k][7:0]});
    end
    for (int k = 0; k < 9; k++) begin
      cmd({8'hF1, wr_tbl[k]}, 3);
    end
    for (int k = 0; k < 4; k++) begin
      cmd({8'hE1, back[k][15:8], 8'h00}, 2);
      rsp("map readback", 1, {56'h0, back[k][7:0]});
    end
    check("before restart", {bus_address, bias_x, mount_correction}, {7'h19, 32'h0});
    cmd(24'h820000, 1);
    adr_w = 8'h40;
    check("after restart", {bus_address, bias_x, mount_correction, smoothing_weight, pwr_mode, filter_active,
      rate_sel}, {7'h20, 16'h005A, 16'hF8F8, 8'h04, CCI_PWR_RUN, 1'h1, 2'h2});
    @(negedge clk_sys);
    i_mst.wr(8'h32, 24'h650000, 1, nak);
    check("old address", 64'(nak), 64'h2);
    cmd(24'h760000, 1);
    check("standby filter", {pwr_mode, filter_active}, {CCI_PWR_STBY, 1'h0});
  endtask : map_access
  // ==========
  // main sequence
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    #2ms;
    n_fail++;
    results();
  end
  initial begin
    rst_b = 1'b1;
    n_fail = 0;
    checked = 0;
    adr_w = 8'h32;
    sens = '{default: 16'h0000};
    // a real falling edge after time zero, so no async reset is lost to start-up order
    #1 rst_b = 1'b0;
    do_reset();
    reset_state();
    data_reads();
    mode_cmds();
    map_access();
    do_reset();
    reset_state();
    results();
  end
endmodule : test_compass_i2c_command_interpreter
